// *** common/lic_pkg.sv ***
// shared constants for the line interface configuration register bank
package lic_pkg;
	localparam int NUM_CH = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// register offsets
	localparam logic [7:0] ADDR_LOS = 8'h04;
	localparam logic [7:0] ADDR_AUTO_ALL_ONES = 8'h0e;
	localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h0f;
	localparam logic [7:0] ADDR_TMPL_PTR = 8'h10;
	localparam logic [7:0] ADDR_TMPL_SEL = 8'h11;
	localparam logic [7:0] ADDR_DRV_OE = 8'h12;
	localparam logic [7:0] ADDR_ALARM_STAT = 8'h13;
	localparam logic [7:0] ADDR_ALARM_MASK = 8'h14;
	localparam logic [7:0] ADDR_ALARM_INT = 8'h15;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_TMPL = 3'h0;
	// global configuration field positions
	localparam int GCF_ALARM_INS = 6;
	localparam int GCF_SHORT_OFF = 5;
	localparam int GCF_CODE = 4;
	localparam int GCF_DEPTH = 3;
	localparam int GCF_BW = 2;
	localparam int GCF_PLACE_HI = 1;
	localparam int GCF_PLACE_LO = 0;
	// writable bits of global configuration (bit 7 reserved)
	localparam logic [7:0] GCF_WMASK = 8'h7f;
	localparam int TMPL_W = 3;
	// attenuator placement codes
	localparam logic [1:0] PLACE_TX = 2'h1;
	localparam logic [1:0] PLACE_RX = 2'h3;
	// template codes
	localparam logic [2:0] TMPL_E1 = 3'h0;
	localparam logic [2:0] TMPL_T1_FIRST = 3'h3;
endpackage

// *** core/lic_edge_flag.sv ***
// one sticky change flag: set on any edge of a masked status bit, cleared by read
`timescale 1ns/1ps
`default_nettype none
module lic_edge_flag (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic status,
	input wire logic mask,
	input wire logic clear,
	output logic flag
);
	logic prev_q, prev_d;
	logic flag_q, flag_d;

	// next values: set dominates the read-clear
	always_comb begin
		prev_d = status;
		flag_d = flag_q;
		if (clear) begin
			flag_d = 1'b0;
		end
		if (mask && (status != prev_q)) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prev_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			flag_q <= flag_d;
		end
	end

	assign flag = flag_q;
endmodule
`default_nettype wire

// *** core/lic_channel_ctl.sv ***
// per-channel line control derived from configuration and receive status
`timescale 1ns/1ps
`default_nettype none
module lic_channel_ctl (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic los,
	input wire logic auto_ones_en,
	input wire logic alarm_ins_en,
	input wire logic oe_off,
	output logic send_all_ones,
	output logic insert_alarm,
	output logic driver_hiz
);
	logic ones_q, ones_d, ins_q, ins_d, hiz_q, hiz_d;

	// registered control levels
	always_comb begin
		ones_d = auto_ones_en & los;
		ins_d = alarm_ins_en & los;
		hiz_d = oe_off;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ones_q <= 1'b0;
			ins_q <= 1'b0;
			hiz_q <= 1'b0;
		end else begin
			ones_q <= ones_d;
			ins_q <= ins_d;
			hiz_q <= hiz_d;
		end
	end

	assign send_all_ones = ones_q;
	assign insert_alarm = ins_q;
	assign driver_hiz = hiz_q;
endmodule
`default_nettype wire

// *** core/lic_regs.sv ***
// line interface configuration register bank with per-channel controls
// Functional notes
// - Channel with auto all-ones bit set sends all ones while in loss of signal.
// - Global alarm insert bit sends alarm toward system on lossy channels.
// - Short protection stays on while global bit 5 is zero.
// - Global bit 4 selects B8ZS/HDB3 at zero, AMI at one.
// - Global bit 3 selects attenuator depth: 32 bits at zero, 64 at one.
// - Global bit 2 selects low or high jitter corner frequency.
// - Placement 01 transmit path, 11 receive path, otherwise unused.
// - Channel pointer picks which channel the template register accesses.
// - Three-bit template picks E1 shape or T1 cable length shapes.
// - Output enable bit one puts that channel's driver high impedance.
// - Alarm status register shows each channel's live alarm detection.
// - Alarm mask bit one lets that channel's changes raise interrupts.
// - Alarm interrupt bit sets on any change while its mask is one.
// - Alarm interrupt bits reset to zero and clear on status read.
// - Loss status reads one while receiver detects loss of signal.
`timescale 1ns/1ps
`default_nettype none
module lic_regs #(
	parameter int NUM_CH = lic_pkg::NUM_CH
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [lic_pkg::ADDR_W-1:0] host_addr,
	input wire logic [lic_pkg::DATA_W-1:0] host_wdata,
	output logic [lic_pkg::DATA_W-1:0] host_rdata,
	input wire logic [NUM_CH-1:0] rx_los,
	input wire logic [NUM_CH-1:0] rx_alarm,
	output logic [NUM_CH-1:0] tx_all_ones,
	output logic [NUM_CH-1:0] sys_alarm_insert,
	output logic [NUM_CH-1:0] tx_driver_hiz,
	output logic [NUM_CH-1:0][lic_pkg::TMPL_W-1:0] tx_template,
	output logic short_protect_on,
	output logic line_code_ami,
	output logic attenuator_depth_select,
	output logic attenuator_bandwidth_select,
	output logic attenuator_in_tx,
	output logic attenuator_in_rx,
	output logic alarm_irq
);
	// refuse any channel count other than the byte-wide register width of 8, at elaboration
	if (NUM_CH != lic_pkg::NUM_CH) begin : g_bad_ch
		$error("channel count must equal the 8-bit register width");
	end

	logic [7:0] auto_ones_q, auto_ones_d;
	logic [7:0] gcfg_q, gcfg_d;
	logic [2:0] tptr_q, tptr_d;
	logic [NUM_CH-1:0][lic_pkg::TMPL_W-1:0] tmpl_q, tmpl_d;
	logic [7:0] oe_q, oe_d;
	logic [7:0] amask_q, amask_d;
	logic [7:0] rdata_q, rdata_d;
	logic [1:0] place_q, place_d;
	logic [NUM_CH-1:0] aflag;
	logic alarm_read;

	// a read of the alarm status register clears the interrupt bits
	assign alarm_read = host_rd && (host_addr == lic_pkg::ADDR_ALARM_STAT);

	// register write decode
	always_comb begin
		auto_ones_d = auto_ones_q;
		gcfg_d = gcfg_q;
		tptr_d = tptr_q;
		tmpl_d = tmpl_q;
		oe_d = oe_q;
		amask_d = amask_q;
		if (host_wr) begin
			case (host_addr)
				lic_pkg::ADDR_AUTO_ALL_ONES: begin
					auto_ones_d = host_wdata;
				end
				lic_pkg::ADDR_GLOBAL_CFG: begin
					gcfg_d = host_wdata & lic_pkg::GCF_WMASK;
				end
				lic_pkg::ADDR_TMPL_PTR: begin
					tptr_d = host_wdata[2:0];
				end
				lic_pkg::ADDR_TMPL_SEL: begin
					tmpl_d[tptr_q] = host_wdata[lic_pkg::TMPL_W-1:0];
				end
				lic_pkg::ADDR_DRV_OE: begin
					oe_d = host_wdata;
				end
				lic_pkg::ADDR_ALARM_MASK: begin
					amask_d = host_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// read mux, registered
	always_comb begin
		rdata_d = lic_pkg::RST_BYTE;
		if (host_rd) begin
			case (host_addr)
				lic_pkg::ADDR_LOS: rdata_d = rx_los;
				lic_pkg::ADDR_AUTO_ALL_ONES: rdata_d = auto_ones_q;
				lic_pkg::ADDR_GLOBAL_CFG: rdata_d = gcfg_q;
				lic_pkg::ADDR_TMPL_PTR: rdata_d = {5'h0, tptr_q};
				lic_pkg::ADDR_TMPL_SEL: rdata_d = {5'h0, tmpl_q[tptr_q]};
				lic_pkg::ADDR_DRV_OE: rdata_d = oe_q;
				lic_pkg::ADDR_ALARM_STAT: rdata_d = rx_alarm;
				lic_pkg::ADDR_ALARM_MASK: rdata_d = amask_q;
				lic_pkg::ADDR_ALARM_INT: rdata_d = aflag;
				default: rdata_d = lic_pkg::RST_BYTE;
			endcase
		end
	end

	always_comb begin
		place_d = gcfg_q[lic_pkg::GCF_PLACE_HI:lic_pkg::GCF_PLACE_LO];
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			auto_ones_q <= lic_pkg::RST_BYTE;
			gcfg_q <= lic_pkg::RST_BYTE;
			tptr_q <= lic_pkg::RST_TMPL;
			tmpl_q <= '0;
			oe_q <= lic_pkg::RST_BYTE;
			amask_q <= lic_pkg::RST_BYTE;
			rdata_q <= lic_pkg::RST_BYTE;
			place_q <= 2'h0;
		end else begin
			auto_ones_q <= auto_ones_d;
			gcfg_q <= gcfg_d;
			tptr_q <= tptr_d;
			tmpl_q <= tmpl_d;
			oe_q <= oe_d;
			amask_q <= amask_d;
			rdata_q <= rdata_d;
			place_q <= place_d;
		end
	end

	// per-channel datapath controls and change flags
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		lic_channel_ctl u_ctl (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.los(rx_los[ch]),
			.auto_ones_en(auto_ones_q[ch]),
			.alarm_ins_en(gcfg_q[lic_pkg::GCF_ALARM_INS]),
			.oe_off(oe_q[ch]),
			.send_all_ones(tx_all_ones[ch]),
			.insert_alarm(sys_alarm_insert[ch]),
			.driver_hiz(tx_driver_hiz[ch])
		);
		lic_edge_flag u_flag (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.status(rx_alarm[ch]),
			.mask(amask_q[ch]),
			.clear(alarm_read),
			.flag(aflag[ch])
		);
	end

	assign host_rdata = rdata_q;
	assign tx_template = tmpl_q;
	assign short_protect_on = ~gcfg_q[lic_pkg::GCF_SHORT_OFF];
	assign line_code_ami = gcfg_q[lic_pkg::GCF_CODE];
	assign attenuator_depth_select = gcfg_q[lic_pkg::GCF_DEPTH];
	assign attenuator_bandwidth_select = gcfg_q[lic_pkg::GCF_BW];
	assign attenuator_in_tx = (place_q == lic_pkg::PLACE_TX);
	assign attenuator_in_rx = (place_q == lic_pkg::PLACE_RX);
	assign alarm_irq = |aflag;
endmodule
`default_nettype wire

// *** sim/lic_regs_asserts.sv ***
// port assertions for the register bank
`timescale 1ns/1ps
`default_nettype none
module lic_regs_asserts (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic [7:0] rx_los,
	input wire logic [7:0] rx_alarm,
	input wire logic [7:0] tx_all_ones,
	input wire logic [7:0] sys_alarm_insert,
	input wire logic [7:0] tx_driver_hiz,
	input wire logic short_protect_on,
	input wire logic line_code_ami,
	input wire logic alarm_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// decoded host accesses
	wire logic cfg_wr = host_wr && host_addr == 8'h0f;
	wire logic alm_rd = host_rd && host_addr == 8'h13;
	a_cfg_bits: assert property (
		cfg_wr |=> short_protect_on != $past(host_wdata[5]) && line_code_ami == $past(host_wdata[4]))
		else $error("config outputs wrong");
	a_hiz_copy: assert property (
		host_wr && host_addr == 8'h12 |=> ##1 tx_driver_hiz == $past(host_wdata, 2))
		else $error("driver high-z wrong");
	a_ones_need_los: assert property ((tx_all_ones & ~$past(rx_los)) == 8'h00)
		else $error("all ones without loss");
	a_insert_need_los: assert property ((sys_alarm_insert & ~$past(rx_los)) == 8'h00)
		else $error("alarm insert without loss");
	a_irq_quiet: assert property (!alarm_irq && $stable(rx_alarm) |=> !alarm_irq)
		else $error("interrupt without change");
	a_irq_sticky: assert property (alarm_irq && !alm_rd |=> alarm_irq)
		else $error("interrupt dropped early");
	a_alarm_read: assert property (alm_rd |=> host_rdata == $past(rx_alarm))
		else $error("alarm status read wrong");
	a_los_read: assert property (
		host_rd && host_addr == 8'h04 |=> host_rdata == $past(rx_los))
		else $error("loss status read wrong");
endmodule
bind lic_regs lic_regs_asserts u_lic_chk (.core_clk(core_clk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
	.host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .rx_los(rx_los), .rx_alarm(rx_alarm),
	.tx_all_ones(tx_all_ones), .sys_alarm_insert(sys_alarm_insert), .tx_driver_hiz(tx_driver_hiz),
	.short_protect_on(short_protect_on), .line_code_ami(line_code_ami), .alarm_irq(alarm_irq));
`default_nettype wire

// *** sim/lic_regs_tb_top.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module lic_regs_tb_top;
	logic core_clk = 0;
	logic rst_n = 0;
	logic host_wr = 0;
	logic host_rd = 0;
	logic [7:0] host_addr = 8'h00;
	logic [7:0] host_wdata = 8'h00;
	logic [7:0] rx_los = 8'h00;
	logic [7:0] rx_alarm = 8'h00;
	logic [7:0] rdat, ones, ins, hiz, g, m, k, v;
	logic [7:0][2:0] tmpl;
	logic prot, ami, dep, bw, itx, irx, irq;
	logic [2:0] tv [8];
	int n_mismatch = 0;
	int n_compared = 0;
	lic_regs dut (.core_clk(core_clk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(rdat), .rx_los(rx_los), .rx_alarm(rx_alarm), .tx_all_ones(ones),
		.sys_alarm_insert(ins), .tx_driver_hiz(hiz), .tx_template(tmpl), .short_protect_on(prot),
		.line_code_ami(ami), .attenuator_depth_select(dep), .attenuator_bandwidth_select(bw),
		.attenuator_in_tx(itx), .attenuator_in_rx(irx), .alarm_irq(irq));
	// clock and watchdog
	initial forever #4 core_clk = ~core_clk;
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
	// comparison, bus cycles and verdict
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		host_wr = 1;
		host_addr = a;
		host_wdata = d;
		@(negedge core_clk);
		host_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge core_clk);
		host_rd = 1;
		host_addr = a;
		@(negedge core_clk);
		host_rd = 0;
		chk(rdat, e);
	endtask
	// expected decoded global configuration outputs, packed as in the compare
	function automatic logic [7:0] cfg_exp(input logic [7:0] gc);
		return {~gc[5], gc[4:2], gc[1:0] == 2'h1, gc[1:0] == 2'h3, 2'h0};
	endfunction
	// expected change flags: masked channels whose alarm level moved
	function automatic logic [7:0] flag_exp(input logic [7:0] msk, input logic [7:0] was, input logic [7:0] now);
		return msk & (was ^ now);
	endfunction
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		v = $urandom(32'h6b81);
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1;
		for (int a = 14; a < 22; a++) rd(a[7:0], 8'h00);
		rd(8'h20, 8'h00);
		chk({7'h00, prot}, 8'h01);
		for (int i = 0; i < 8; i++) begin
			g = $urandom & 8'h7f;
			g[1:0] = i[1:0];
			m = $urandom;
			k = $urandom;
			v = $urandom % 6;
			tv[i] = (v == 0) ? 3'h0 : v[2:0] + 3'h2;
			wr(8'h0f, g);
			wr(8'h10, i[7:0]);
			wr(8'h11, {5'h00, tv[i]});
			wr(8'h0e, m);
			wr(8'h12, ~m);
			rd(8'h0f, g);
			chk({prot, ami, dep, bw, itx, irx, 2'h0}, cfg_exp(g));
			rd(8'h0e, m);
			rd(8'h12, ~m);
			@(negedge core_clk) rx_los = k;
			rd(8'h04, k);
			chk(ones, m & k);
			chk(ins, g[6] ? k : 8'h00);
			chk(hiz, ~m);
			wr(8'h14, k ^ m);
			rd(8'h14, k ^ m);
			rd(8'h13, rx_alarm);
			rd(8'h15, 8'h00);
			v = rx_alarm;
			@(negedge core_clk) rx_alarm = m;
			rd(8'h15, flag_exp(k ^ m, v, m));
			chk({7'h00, irq}, {7'h00, |flag_exp(k ^ m, v, m)});
			rd(8'h13, m);
			rd(8'h15, 8'h00);
		end
		for (int i = 0; i < 8; i++) begin
			wr(8'h10, i[7:0]);
			rd(8'h10, i[7:0]);
			rd(8'h11, {5'h00, tv[i]});
			chk({5'h00, tmpl[i]}, {5'h00, tv[i]});
		end
		// corner: alarm change in the same cycle as the clearing status read, set must win
		wr(8'h14, 8'hff);
		rd(8'h13, rx_alarm);
		v = rx_alarm;
		fork
			rd(8'h13, ~v);
			@(negedge core_clk) rx_alarm = ~v;
		join
		rd(8'h15, flag_exp(8'hff, v, ~v));
		chk({7'h00, irq}, 8'h01);
		rd(8'h13, ~v);
		rd(8'h15, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
